// ===== bdr_defs.vh
// Purpose: shared constants of the backlight dimming register bank
// Assumes: byte-wide register port, 250 MHz system clock
// Notes: definitions only
`ifndef BDR_DEFS_VH
`define BDR_DEFS_VH

// register offsets
`define BDR_ADDR_PWM_LEVEL 8'h00
`define BDR_ADDR_DEV_CTRL 8'h01
`define BDR_ADDR_FLT_STAT 8'h02
`define BDR_ADDR_SI_ID 8'h03
`define BDR_ADDR_DC_LEVEL 8'h07
`define BDR_ADDR_DRV_CFG 8'h08

// reset values
`define BDR_RST_PWM_LEVEL 8'hff
`define BDR_RST_DEV_CTRL 8'h00
`define BDR_RST_DC_LEVEL 8'hff
`define BDR_RST_DRV_CFG 8'h1f

// device control fields
`define BDR_CTL_ON 0
`define BDR_CTL_SRC 1
`define BDR_CTL_INTERP 2

// fault / status fields
`define BDR_ST_FAULT 0
`define BDR_ST_THERM 1
`define BDR_ST_OVC 2
`define BDR_ST_BL 3
`define BDR_ST_ONE_SD 4
`define BDR_ST_TWO_SD 5

// identification fields
`define BDR_ID_PANEL 7
`define BDR_ID_MAKER_HI 6
`define BDR_ID_MAKER_LO 3
`define BDR_ID_REV_HI 2
`define BDR_ID_REV_LO 0

// configuration fields
`define BDR_CFG_FOLLOW 6
`define BDR_CFG_TO_DC 5
`define BDR_CFG_SLEW_HI 4
`define BDR_CFG_SLEW_LO 3
`define BDR_CFG_FSW 2
`define BDR_CFG_VSC_HI 1
`define BDR_CFG_VSC_LO 0

// duty steps: a period of 255 ticks, step 255 is full on
`define BDR_DUTY_FULL 8'hff
`define BDR_DUTY_LAST 8'hfe

// timing
`define BDR_CLK_PERIOD_NS 4
`define BDR_ON_TIME_NS 4000000
`define BDR_TICK_DIV 16

`endif

// ===== bdr_pwm_gen.v
// Purpose: duty-step waveform generator
// Assumes: one tick enable per duty step
// Notes: period is 255 ticks so step 255 gives 100 percent
`timescale 1ns/1ns
`default_nettype none
`include "bdr_defs.vh"
module bdr_pwm_gen (
  input wire i_clk_sys, // system clock
  input wire i_arst_n, // async reset, low
  input wire i_tick, // step enable
  input wire [7:0] i_duty, // duty step 0..255
  output reg o_pwm // duty waveform
);
  reg [7:0] step_cnt; // position in period

  // step counter wraps after the last step
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      step_cnt <= 8'h00;
      o_pwm <= 1'b0;
    end else if (i_tick) begin
      if (step_cnt == `BDR_DUTY_LAST)
        step_cnt <= 8'h00;
      else
        step_cnt <= step_cnt + 8'h01;
      // step 0 never high, 255 always high
      o_pwm <= (step_cnt < i_duty);
    end
  end
endmodule
`default_nettype wire

// ===== bdr_duty_meter.v
// Purpose: measures duty of the external dimming input
// Assumes: input already synchronous to the clock
// Notes: result refreshes once per 255-tick window
`timescale 1ns/1ns
`default_nettype none
`include "bdr_defs.vh"
module bdr_duty_meter (
  input wire i_clk_sys, // system clock
  input wire i_arst_n, // async reset, low
  input wire i_tick, // sample enable
  input wire i_level, // sampled waveform
  output reg [7:0] o_duty // measured duty step
);
  reg [7:0] win_cnt; // ticks in window
  reg [7:0] high_cnt; // high samples in window

  // count high samples, latch at window end
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      win_cnt <= 8'h00;
      high_cnt <= 8'h00;
      o_duty <= 8'h00;
    end else if (i_tick) begin
      if (win_cnt == `BDR_DUTY_LAST) begin
        win_cnt <= 8'h00;
        high_cnt <= 8'h00;
        o_duty <= high_cnt + {7'h00, i_level};
      end else begin
        win_cnt <= win_cnt + 8'h01;
        high_cnt <= high_cnt + {7'h00, i_level};
      end
    end
  end
endmodule
`default_nettype wire

// ===== bdr_register_bank.v
// Purpose: register bank of a six-channel backlight dimming driver
// Assumes: byte read/write strobes from an SMBus protocol engine
// Notes: channel enables and faults come from the channel block
`timescale 1ns/1ns
`default_nettype none
`include "bdr_defs.vh"
module bdr_register_bank #(
  parameter [3:0] P_MAKER_CODE = 4'hf, // arbitrary; 15 = none
  parameter [2:0] P_SI_REV = 3'h0, // first shipped revision
  parameter P_ON_CYC = `BDR_ON_TIME_NS / `BDR_CLK_PERIOD_NS,
  parameter P_ON_W = 20, // width of on-delay counter
  parameter P_TICK_DIV = `BDR_TICK_DIV, // clocks per duty tick
  parameter P_CH = 6 // number of channels
) (
  input wire i_clk_sys, // system clock
  input wire i_arst_n, // async reset, low
  input wire i_reg_wr, // byte write strobe
  input wire i_reg_rd, // byte read strobe
  input wire [7:0] i_reg_addr, // register offset
  input wire [7:0] i_reg_wdata, // write byte
  input wire i_external_dimming_input, // external PWM pin
  input wire i_thermal_trip, // thermal detector
  input wire i_input_overcurrent, // overcurrent detector
  input wire [P_CH-1:0] i_channel_enable, // channel enables
  input wire [P_CH-1:0] i_channel_fault, // channels faulted out
  output reg [7:0] o_reg_rdata, // read byte
  output reg o_reg_rvalid, // read data valid pulse
  output reg o_backlight_on, // backlight is on
  output reg o_led_drive, // current source gate
  output reg [7:0] o_current_level, // DC current step
  output reg [1:0] o_gate_drive_strength, // boost drive
  output reg o_switching_rate_select, // 0 1200k, 1 600k
  output reg [1:0] o_short_threshold, // short detect level
  output reg [P_CH-1:0] o_channel_status // channel readback
);

  // power sequence states
  localparam [2:0] ST_OFF = 3'b001; // backlight off
  localparam [2:0] ST_RAMP = 3'b010; // waiting to come on
  localparam [2:0] ST_ON = 3'b100; // backlight on

  // dimming source modes
  localparam [2:0] MD_COMB = 3'b001; // serial and PWM
  localparam [2:0] MD_EXT = 3'b010; // external input
  localparam [2:0] MD_SER = 3'b100; // serial only

  // register storage
  reg [7:0] duty_level_field; // PWM brightness
  reg [7:0] device_control; // full byte, reserved kept
  reg [7:0] current_level_field; // DC brightness
  reg [7:0] driver_configuration; // configuration byte
  reg summary_fault; // sticky fault bit
  reg thermal_trip_flag; // live thermal status
  reg input_overcurrent_flag; // live overcurrent status
  reg single_channel_shutdown_flag; // one or more down
  reg multi_channel_shutdown_flag; // two or more down

  // sequence and mode state
  reg [2:0] pwr_state; // power state
  reg [2:0] next_pwr_state; // next power state
  reg [2:0] dim_mode; // active dimming mode
  reg [P_ON_W-1:0] on_cnt; // on-delay counter
  reg [P_ON_W-1:0] next_on_cnt; // next on-delay count
  reg [7:0] tick_cnt; // tick divider
  reg tick; // one-cycle tick enable

  // decoded strobes
  wire wr_pwm = i_reg_wr && (i_reg_addr == `BDR_ADDR_PWM_LEVEL);
  wire wr_ctl = i_reg_wr && (i_reg_addr == `BDR_ADDR_DEV_CTRL);
  wire wr_st = i_reg_wr && (i_reg_addr == `BDR_ADDR_FLT_STAT);
  wire wr_dc = i_reg_wr && (i_reg_addr == `BDR_ADDR_DC_LEVEL);
  wire wr_cfg = i_reg_wr && (i_reg_addr == `BDR_ADDR_DRV_CFG);

  // control fields
  wire backlight_on_request = device_control[`BDR_CTL_ON];
  wire new_on = i_reg_wdata[`BDR_CTL_ON];
  wire [1:0] new_sel = {i_reg_wdata[`BDR_CTL_INTERP],
                        i_reg_wdata[`BDR_CTL_SRC]};
  wire input_follow_enable = driver_configuration[`BDR_CFG_FOLLOW];
  wire duty_to_current_enable = driver_configuration[`BDR_CFG_TO_DC];

  // count of faulted, enabled channels
  wire [P_CH-1:0] ch_down = i_channel_fault & i_channel_enable;
  reg [3:0] down_cnt; // faulted channel count
  integer k; // loop index

  // waveform and duty paths
  wire [7:0] ext_duty; // measured external duty
  wire [7:0] eff_duty; // duty for the generator
  wire gen_pwm; // generated waveform
  wire fault_cause; // any reportable fault

  // scales a by b/256; 255 on either input passes the other through exactly
  function [7:0] bdr_scale;
    input [7:0] a;
    input [7:0] b;
    reg [15:0] prod;
    begin
      prod = a * b;
      if (a == `BDR_DUTY_FULL)
        bdr_scale = b;
      else if (b == `BDR_DUTY_FULL)
        bdr_scale = a;
      else
        bdr_scale = prod[15:8];
    end
  endfunction

  // tick divider for duty stepping
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (tick_cnt == P_TICK_DIV - 1) begin
      tick_cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // count faulted-out channels
  always @* begin
    down_cnt = 4'h0;
    for (k = 0; k < P_CH; k = k + 1)
      down_cnt = down_cnt + {3'h0, ch_down[k]};
  end

  // power sequence: off at once, on after the delay
  always @* begin
    next_pwr_state = pwr_state;
    next_on_cnt = on_cnt;
    case (pwr_state)
      ST_OFF: begin
        next_on_cnt = {P_ON_W{1'b0}};
        if (wr_ctl && new_on)
          next_pwr_state = ST_RAMP;
      end
      ST_RAMP: begin
        next_on_cnt = on_cnt + {{(P_ON_W-1){1'b0}}, 1'b1};
        if (wr_ctl && !new_on)
          next_pwr_state = ST_OFF;
        else if (on_cnt == P_ON_CYC - 1)
          next_pwr_state = ST_ON; // within the on time
      end
      ST_ON: begin
        if (wr_ctl && !new_on)
          next_pwr_state = ST_OFF;
      end
      default: begin
        next_pwr_state = ST_OFF;
        next_on_cnt = {P_ON_W{1'b0}};
      end
    endcase
  end

  // power state registers
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr_state <= ST_OFF;
      on_cnt <= {P_ON_W{1'b0}};
    end else begin
      pwr_state <= next_pwr_state;
      on_cnt <= next_on_cnt;
    end
  end

  // mode decode; 11 keeps the previous mode
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dim_mode <= MD_COMB;
    end else if (wr_ctl && new_on) begin
      case (new_sel)
        2'b00: dim_mode <= MD_COMB;
        2'b01: dim_mode <= MD_EXT;
        2'b10: dim_mode <= MD_SER;
        default: dim_mode <= dim_mode;
      endcase
    end
  end

  // writable registers
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      duty_level_field <= `BDR_RST_PWM_LEVEL;
      device_control <= `BDR_RST_DEV_CTRL;
      current_level_field <= `BDR_RST_DC_LEVEL;
      driver_configuration <= `BDR_RST_DRV_CFG;
    end else begin
      // external mode ignores brightness writes
      if (wr_pwm && dim_mode != MD_EXT)
        duty_level_field <= i_reg_wdata;
      // whole byte latched, reserved bits too
      if (wr_ctl)
        device_control <= i_reg_wdata;
      // dc level alone, applies at once
      if (wr_dc)
        current_level_field <= i_reg_wdata;
      if (wr_cfg)
        driver_configuration <= i_reg_wdata;
    end
  end

  // only faults seen while fully on set the sticky summary
  assign fault_cause = (pwr_state == ST_ON) &&
    (i_thermal_trip || i_input_overcurrent ||
     (down_cnt != 4'h0));

  // live status flags and sticky summary
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      summary_fault <= 1'b0;
      thermal_trip_flag <= 1'b0;
      input_overcurrent_flag <= 1'b0;
      single_channel_shutdown_flag <= 1'b0;
      multi_channel_shutdown_flag <= 1'b0;
    end else begin
      thermal_trip_flag <= i_thermal_trip;
      input_overcurrent_flag <= i_input_overcurrent;
      // at least one and at least two channels
      single_channel_shutdown_flag <= (down_cnt >= 4'h1);
      multi_channel_shutdown_flag <= (down_cnt >= 4'h2);
      // a new fault beats a clear in the same cycle
      if (fault_cause)
        summary_fault <= 1'b1;
      else if (wr_ctl && (new_on != backlight_on_request))
        summary_fault <= 1'b0; // toggle clears
      else if (wr_st && !i_reg_wdata[`BDR_ST_FAULT])
        summary_fault <= 1'b0; // other status bits ignored
    end
  end

  // duty source per mode
  assign eff_duty = (dim_mode == MD_EXT) ? ext_duty :
                    (dim_mode == MD_SER) ? duty_level_field :
                    bdr_scale(duty_level_field, ext_duty);

  // duty waveform from the selected level
  bdr_pwm_gen u_pwm_gen (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_duty(eff_duty),
    .o_pwm(gen_pwm)
  );

  // external input duty for mixing and scaling
  bdr_duty_meter u_duty_meter (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_level(i_external_dimming_input),
    .o_duty(ext_duty)
  );

  // drive outputs; off forces everything to zero
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_backlight_on <= 1'b0;
      o_led_drive <= 1'b0;
      o_current_level <= 8'h00;
      o_channel_status <= {P_CH{1'b0}};
    end else if (next_pwr_state != ST_ON) begin
      o_backlight_on <= 1'b0;
      o_led_drive <= 1'b0;
      o_current_level <= 8'h00;
      o_channel_status <= {P_CH{1'b0}};
    end else begin
      o_backlight_on <= 1'b1;
      o_channel_status <= i_channel_enable & ~i_channel_fault;
      if (input_follow_enable) begin
        // current follows the input pin
        o_led_drive <= i_external_dimming_input;
        o_current_level <= current_level_field;
      end else if (duty_to_current_enable) begin
        // sources stay on, level scales with duty
        o_led_drive <= 1'b1;
        o_current_level <= bdr_scale(current_level_field, eff_duty);
      end else begin
        o_led_drive <= gen_pwm;
        o_current_level <= current_level_field;
      end
    end
  end

  // boost and short-detect settings go straight out
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gate_drive_strength <= 2'h0;
      o_switching_rate_select <= 1'b0;
      o_short_threshold <= 2'h0;
    end else begin
      // 00 25, 01 50, 10 75, 11 100 percent
      o_gate_drive_strength <=
        driver_configuration[`BDR_CFG_SLEW_HI:`BDR_CFG_SLEW_LO];
      // 0 selects 1200kHz, 1 selects 600kHz
      o_switching_rate_select <= driver_configuration[`BDR_CFG_FSW];
      // 0 off, 1 3.6V, 2 4.8V, 3 5.8V
      o_short_threshold <=
        driver_configuration[`BDR_CFG_VSC_HI:`BDR_CFG_VSC_LO];
    end
  end

  // read mux, one cycle after the strobe
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `BDR_ADDR_PWM_LEVEL:
            o_reg_rdata <= duty_level_field;
          `BDR_ADDR_DEV_CTRL:
            o_reg_rdata <= device_control;
          `BDR_ADDR_FLT_STAT:
            // reserved bits 7:6 read zero
            o_reg_rdata <= {2'b00,
              multi_channel_shutdown_flag,
              single_channel_shutdown_flag,
              (pwr_state == ST_ON),
              input_overcurrent_flag,
              thermal_trip_flag,
              summary_fault};
          `BDR_ADDR_SI_ID:
            // panel bit, maker, revision
            o_reg_rdata <= {1'b1, P_MAKER_CODE, P_SI_REV};
          `BDR_ADDR_DC_LEVEL:
            o_reg_rdata <= current_level_field;
          `BDR_ADDR_DRV_CFG:
            o_reg_rdata <= driver_configuration;
          default:
            o_reg_rdata <= 8'h00; // unmapped reads zero
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== bdr_host_model.sv
// Purpose: byte read/write host standing in for the serial engine
// Assumes: requests launched on the falling clock edge
// Notes: address and data scrambled while idle, never left stale
`timescale 1ns/1ns
`default_nettype none
module bdr_host_model (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reg_rvalid, // read data valid
  input wire logic [7:0] i_reg_rdata, // read byte
  output var logic o_reg_wr, // write strobe
  output var logic o_reg_rd, // read strobe
  output var logic [7:0] o_reg_addr, // register offset
  output var logic [7:0] o_reg_wdata // write byte
);
  // idle bus from time zero
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // single write-byte, one strobe cycle
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_clk_sys);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a; // released, so no stale offset
    o_reg_wdata = ~d;
  endtask
  // single read-byte; the answer is awaited under a bound
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
                           output logic ok);
    int n;
    @(negedge i_clk_sys);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_clk_sys);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    n = 0;
    while (i_reg_rvalid !== 1'b1 && n < 8) begin
      @(negedge i_clk_sys);
      n++;
    end
    ok = i_reg_rvalid;
    d = i_reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== bdr_reg_chk_assertions.sv
// Purpose: port assertions for the backlight register bank
// Assumes: one clock domain, asynchronous low reset
// Notes: shadows of the control and config bytes live here
`timescale 1ns/1ns
`default_nettype none
module bdr_reg_chk #(
  parameter [3:0] P_MAKER_CODE = 4'hf, // arbitrary maker value
  parameter [2:0] P_SI_REV = 3'h0, // silicon revision
  parameter P_ON_CYC = 20, // on delay in cycles
  parameter P_CH = 6 // channel count
) (
  input wire logic i_clk_sys, // clock
  input wire logic i_arst_n, // reset, low
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [7:0] i_reg_addr, // offset
  input wire logic [7:0] i_reg_wdata, // write byte
  input wire logic i_external_dimming_input, // dimming input
  input wire logic [P_CH-1:0] i_channel_enable, // enables
  input wire logic [P_CH-1:0] i_channel_fault, // faults
  input wire logic [7:0] o_reg_rdata, // read byte
  input wire logic o_reg_rvalid, // read valid
  input wire logic o_backlight_on, // backlight state
  input wire logic o_led_drive, // source gate
  input wire logic [7:0] o_current_level, // dc step
  input wire logic [1:0] o_gate_drive_strength, // drive
  input wire logic o_switching_rate_select, // rate
  input wire logic [1:0] o_short_threshold, // short level
  input wire logic [P_CH-1:0] o_channel_status // readback
);
  logic [7:0] ctl_q; // last control byte written
  logic [7:0] cfg_q; // last config byte written
  logic [7:0] cfg_p; // config one cycle older, as the bank used it
  int on_cnt; // cycles enabled but not yet on
  wire wr_ctl = i_reg_wr && i_reg_addr == 8'h01;
  // shadows and on-delay counter
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_q <= 8'h00;
      cfg_q <= 8'h1f;
      cfg_p <= 8'h1f;
      on_cnt <= 0;
    end else begin
      cfg_p <= cfg_q;
      if (wr_ctl) ctl_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 8'h08) cfg_q <= i_reg_wdata;
      if (ctl_q[0] && !o_backlight_on) on_cnt <= on_cnt + 1;
      else on_cnt <= 0; // off or already on
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  read_answer_a: assert property (
    o_reg_rvalid == $past(i_reg_rd)) else $error("read valid misplaced");
  id_value_a: assert property (
    i_reg_rd && i_reg_addr == 8'h03 |=>
      o_reg_rdata == {1'b1, P_MAKER_CODE, P_SI_REV})
    else $error("identification byte wrong");
  ctl_read_a: assert property (
    i_reg_rd && i_reg_addr == 8'h01 |=> o_reg_rdata == $past(ctl_q))
    else $error("control readback wrong");
  stat_rsvd_a: assert property (
    i_reg_rd && i_reg_addr == 8'h02 |=> o_reg_rdata[7:6] == 2'h0)
    else $error("status reserved bits set");
  off_now_a: assert property (
    wr_ctl && !i_reg_wdata[0] |=> !o_backlight_on &&
      o_channel_status == '0 && o_current_level == 8'h00)
    else $error("backlight not off at once");
  on_time_a: assert property (
    $rose(o_backlight_on) |-> on_cnt == P_ON_CYC)
    else $error("on delay wrong");
  on_bound_a: assert property (
    on_cnt <= P_ON_CYC) else $error("backlight late");
  chan_ok_a: assert property (
    o_backlight_on && $past(o_backlight_on) |-> o_channel_status ==
      ($past(i_channel_enable) & ~$past(i_channel_fault)))
    else $error("channel readback wrong");
  cfg_out_a: assert property (
    i_reg_wr && i_reg_addr == 8'h08 |=> ##1 {o_gate_drive_strength,
      o_switching_rate_select, o_short_threshold} == cfg_q[4:0])
    else $error("config outputs wrong");
  follow_in_a: assert property (
    cfg_p[6] && o_backlight_on && $past(o_backlight_on) |->
      o_led_drive == $past(i_external_dimming_input))
    else $error("drive does not follow input");
  dc_on_a: assert property (
    cfg_p[5] && !cfg_p[6] && o_backlight_on && $past(o_backlight_on)
      |-> o_led_drive) else $error("sources not held on");
  cover property ($rose(o_backlight_on));
  cover property (o_reg_rvalid && o_reg_rdata[0]);
  cover property (cfg_p[6] && o_backlight_on);
endmodule
bind bdr_register_bank bdr_reg_chk #(.P_MAKER_CODE(P_MAKER_CODE),
  .P_SI_REV(P_SI_REV), .P_ON_CYC(P_ON_CYC), .P_CH(P_CH)) u_chk (
  .i_clk_sys, .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .i_external_dimming_input, .i_channel_enable, .i_channel_fault,
  .o_reg_rdata, .o_reg_rvalid, .o_backlight_on, .o_led_drive,
  .o_current_level, .o_gate_drive_strength, .o_switching_rate_select,
  .o_short_threshold, .o_channel_status);
`default_nettype wire

// ===== backlight_dimming_register_bank_tb_top.sv
// Purpose: self-checking bench for the backlight register bank
// Assumes: on delay cut to 20 cycles, duty tick every 2 clocks
// Notes: table rows first, then power, dimming and fault cases
`timescale 1ns/1ns
`default_nettype none
module backlight_dimming_register_bank_tb_top;
  localparam int ON = 20; // shortened on delay
  logic i_clk_sys, i_arst_n, wr, rd, ext, therm, ovc, rvalid, bl_on;
  logic drive, rate, ok;
  logic [7:0] addr, wdata, rdata, level, rb;
  logic [5:0] en, flt, chan;
  logic [1:0] slew, thr;
  int error_cnt = 0, checks = 0, n;
  // row: write flag, offset, write byte, expected read
  logic [31:0] rows [0:24] = '{
    32'h0000_00ff, 32'h0001_0000, 32'h0002_0000, 32'h0003_00f8,
    32'h0007_00ff, 32'h0008_001f, 32'h0005_0000, 32'h0103_00f8,
    32'h0102_3e00, 32'h0107_5a5a, 32'h0100_3c3c, 32'h0101_f8f8,
    32'h0101_0202, 32'h0100_1111, 32'h0101_0606, 32'h0100_2121,
    32'h0101_0404, 32'h0100_2222, 32'h0109_0000, 32'h0108_0000,
    32'h0108_0d0d, 32'h0108_1212, 32'h0108_1b1b, 32'h0108_1f1f,
    32'h0100_ffff};
  // fault row: channel faults, ovc/thermal, clear write, status
  logic [31:0] frows [0:5] = '{32'h0100_0019, 32'h0300_0039,
    32'h0000_0009, 32'h0001_000b, 32'h0002_000d, 32'h0000_0108};
  logic [7:0] duties [0:2] = '{8'h00, 8'h80, 8'hff};
  bdr_register_bank #(.P_ON_CYC(ON), .P_TICK_DIV(2)) uut (
    .i_clk_sys, .i_arst_n, .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_external_dimming_input(ext), .i_thermal_trip(therm),
    .i_input_overcurrent(ovc), .i_channel_enable(en),
    .i_channel_fault(flt), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_backlight_on(bl_on), .o_led_drive(drive), .o_current_level(level),
    .o_gate_drive_strength(slew), .o_switching_rate_select(rate),
    .o_short_threshold(thr), .o_channel_status(chan));
  bdr_host_model host (.i_clk_sys, .i_reg_rvalid(rvalid),
    .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata));
  // 250 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // read a register; a missing answer ends the run
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.read_byte(a, rb, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t no read answer", $time);
      end_of_test;
    end else chk(rb, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // settle past two input-duty windows, then count one full period
  task automatic duty_chk(input logic [7:0] e);
    int h;
    h = 0;
    repeat (1040) @(negedge i_clk_sys);
    repeat (510) begin
      @(negedge i_clk_sys);
      h += int'(drive === 1'b1);
    end
    chk(8'(h / 2), e);
  endtask
  // main sequence
  initial begin
    i_arst_n = 1'b0;
    ext = 1'b0;
    therm = 1'b0;
    ovc = 1'b0;
    en = 6'h3f;
    flt = 6'h00;
    repeat (5) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i][24]) host.write_byte(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0]);
      if (rows[i][31:16] == 16'h0108)
        chk({3'h0, slew, rate, thr}, {3'h0, rows[i][4:0]});
    end
    // power on in serial mode, plain pulse dimming
    host.write_byte(8'h08, 8'h00);
    host.write_byte(8'h01, 8'h05);
    n = 0;
    while (bl_on !== 1'b1 && n < 4 * ON) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk(8'(n), 8'(ON));
    rdchk(8'h02, 8'h08);
    chk({2'h0, chan}, 8'h3f);
    // duty steps 0, 128 and 255, each seen over one full waveform period
    foreach (duties[i]) begin
      host.write_byte(8'h00, duties[i]);
      duty_chk(duties[i]);
    end
    // duty to current, then a level change on the fly
    host.write_byte(8'h08, 8'h20);
    repeat (4) @(negedge i_clk_sys);
    chk({7'h0, drive}, 8'h01);
    chk(level, 8'h5a);
    host.write_byte(8'h07, 8'h33);
    repeat (4) @(negedge i_clk_sys);
    chk(level, 8'h33);
    // drive follows the dimming input
    host.write_byte(8'h08, 8'h40);
    for (int k = 1; k < 10; k++) begin
      ext = k[0] ^ k[2];
      @(negedge i_clk_sys);
    end
    chk({7'h0, drive}, 8'h01);
    ext = 1'b0;
    host.write_byte(8'h08, 8'h00);
    // faults while on: live bits, sticky summary, clear by write
    foreach (frows[i]) begin
      flt = frows[i][29:24];
      therm = frows[i][16];
      ovc = frows[i][17];
      if (frows[i][8]) host.write_byte(8'h02, 8'h00);
      repeat (2) @(negedge i_clk_sys);
      rdchk(8'h02, frows[i][7:0]);
    end
    // latch a fault, then switching off clears it at once
    therm = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    therm = 1'b0;
    host.write_byte(8'h01, 8'h04);
    chk({bl_on, drive, chan}, 8'h00);
    chk(level, 8'h00);
    rdchk(8'h02, 8'h00);
    // quick on then off under a live fault: nothing latched
    therm = 1'b1;
    host.write_byte(8'h01, 8'h05);
    host.write_byte(8'h01, 8'h04);
    repeat (2) @(negedge i_clk_sys);
    rdchk(8'h02, 8'h02);
    therm = 1'b0;
    // external source: input duty used, brightness writes refused
    host.write_byte(8'h01, 8'h03);
    host.write_byte(8'h01, 8'h07);
    host.write_byte(8'h00, 8'h40);
    rdchk(8'h00, 8'hff);
    duty_chk(8'h00);
    // combined: write taken, full input duty keeps the level
    ext = 1'b1;
    host.write_byte(8'h01, 8'h01);
    host.write_byte(8'h00, 8'h80);
    rdchk(8'h00, 8'h80);
    duty_chk(8'h80);
    // second reset restores defaults
    i_arst_n = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    rdchk(8'h00, 8'hff);
    rdchk(8'h07, 8'hff);
    chk({3'h0, slew, rate, thr}, 8'h1f);
    end_of_test;
  end
endmodule
`default_nettype wire
